// [common/lwm_cmd_if.sv]
`timescale 1ns/100ps
`default_nettype none
interface lwm_cmd_if;
  logic       mrw_v;    // Mode register write complete
  logic [5:0] mr_addr;  // Its address
  logic [7:0] mr_op;    // Its operand
  logic       mpc_v;    // Multipurpose command complete
  logic       cas2_v;   // CAS-2 second edge
  logic [6:0] cmd_op;   // Operand of the completed command
  logic       other_v;  // Any other command seen

  modport dec  (output mrw_v, mr_addr, mr_op, mpc_v, cas2_v, cmd_op, other_v);
  modport core (input  mrw_v, mr_addr, mr_op, mpc_v, cas2_v, cmd_op, other_v);
endinterface : lwm_cmd_if
`default_nettype wire

// [common/lwm_pkg.sv]
`default_nettype none
package lwm_pkg;

  // Mode register that holds the leveling enable
  localparam logic [5:0]  MR_LEVEL_ADDR = 6'h02;
  localparam int unsigned MR_LEVEL_BIT  = 7;

  // First-edge CA[4:0] codes of the two-edge commands (CS high)
  localparam logic [4:0] CA_MRW1 = 5'h06;
  localparam logic [4:0] CA_MRW2 = 5'h16;
  localparam logic [4:0] CA_MPC  = 5'h00;
  localparam logic [4:0] CA_CAS2 = 5'h12;

  // Training operands of the multipurpose command
  localparam logic [6:0] OP_RD_FIFO   = 7'h41;
  localparam logic [6:0] OP_RD_CAL    = 7'h43;
  localparam logic [6:0] OP_WR_FIFO   = 7'h47;
  localparam logic [6:0] OP_OSC_START = 7'h4B;
  localparam logic [6:0] OP_OSC_STOP  = 7'h4D;
  localparam logic [6:0] OP_ZQ_START  = 7'h4F;
  localparam logic [6:0] OP_ZQ_LATCH  = 7'h51;

  // Timing
  localparam int unsigned SYS_CLK_PS      = 8000;
  localparam int unsigned FB_DELAY_MAX_NS = 20;
  localparam int unsigned FB_DELAY_RAW    = FB_DELAY_MAX_NS * 1000 / SYS_CLK_PS;
  localparam int unsigned FB_DELAY_CYC    = (FB_DELAY_RAW < 1) ? 1 : FB_DELAY_RAW;
  localparam logic [5:0]  FIRST_EDGE_TCK  = 6'h28;

  // Reset values
  localparam logic       OSC_RESET = 1'b0;
  localparam logic       WL_RESET  = 1'b0;

  typedef enum logic [3:0] {
    MPC_NOP, MPC_RD_FIFO, MPC_RD_CAL, MPC_WR_FIFO, MPC_OSC_START,
    MPC_OSC_STOP, MPC_ZQ_START, MPC_ZQ_LATCH, MPC_RSVD
  } lwm_mpc_t;

  function automatic lwm_mpc_t lwm_mpc_decode(input logic [6:0] op);
    lwm_mpc_t k;
    k = MPC_RSVD;
    if (!op[6])
      k = MPC_NOP;
    else
      case (op)
        OP_RD_FIFO:   k = MPC_RD_FIFO;
        OP_RD_CAL:    k = MPC_RD_CAL;
        OP_WR_FIFO:   k = MPC_WR_FIFO;
        OP_OSC_START: k = MPC_OSC_START;
        OP_OSC_STOP:  k = MPC_OSC_STOP;
        OP_ZQ_START:  k = MPC_ZQ_START;
        OP_ZQ_LATCH:  k = MPC_ZQ_LATCH;
        default:      k = MPC_RSVD;
      endcase
    return k;
  endfunction : lwm_mpc_decode

  function automatic logic lwm_needs_cas2(input lwm_mpc_t k);
    return (k == MPC_RD_FIFO) || (k == MPC_RD_CAL) || (k == MPC_WR_FIFO);
  endfunction : lwm_needs_cas2

endpackage : lwm_pkg
`default_nettype wire

// [hdl/lwm_cmd_dec.sv]
`timescale 1ns/100ps
`default_nettype none
module lwm_cmd_dec (
  input  wire logic       clk_i,    // System clock
  input  wire logic       rst_n_i,  // Synchronised reset, active low
  input  wire logic       edge_i,   // Link clock rising edge seen
  input  wire logic       cs_i,     // Synchronised chip select
  input  wire logic [5:0] ca_i,     // Synchronised command/address
  lwm_cmd_if.dec          bus       // Decoded commands
);

  typedef enum logic [2:0] {
    ST_IDLE, ST_MRW1, ST_MRW2, ST_MPC, ST_CAS2, ST_SKIP
  } lwm_dec_st_t;

  lwm_dec_st_t st_reg, st_next;
  logic       hi_reg, hi_next;
  logic [5:0] ma_reg, ma_next;
  logic       op7_reg, op7_next;
  logic [6:0] out_reg, out_next;
  logic       mrw_reg, mrw_next;
  logic       mpc_reg, mpc_next;
  logic       cas2_reg, cas2_next;
  logic       oth_reg, oth_next;

  always_comb
  begin
    st_next   = st_reg;
    hi_next   = hi_reg;
    ma_next   = ma_reg;
    op7_next  = op7_reg;
    out_next  = out_reg;
    mrw_next  = 1'b0;
    mpc_next  = 1'b0;
    cas2_next = 1'b0;
    oth_next  = 1'b0;
    if (edge_i)
      unique case (st_reg)
        ST_IDLE:
          if (cs_i)
          begin
            hi_next = ca_i[5];  // see RULE17
            unique case (ca_i[4:0])
              lwm_pkg::CA_MRW1: st_next = ST_MRW1;
              lwm_pkg::CA_MRW2: st_next = ST_MRW2;
              lwm_pkg::CA_MPC:  st_next = ST_MPC;  // see RULE16
              lwm_pkg::CA_CAS2: st_next = ST_CAS2;
              default:
              begin
                oth_next = 1'b1;
                st_next  = ST_SKIP;
              end
            endcase
          end
        ST_MRW1:
        begin
          ma_next  = ca_i;
          op7_next = hi_reg;
          st_next  = ST_IDLE;
        end
        ST_MRW2:
        begin
          mrw_next = 1'b1;
          out_next = {hi_reg, ca_i};
          st_next  = ST_IDLE;
        end
        ST_MPC:
        begin
          mpc_next = 1'b1;
          out_next = {hi_reg, ca_i};  // see RULE16
          st_next  = ST_IDLE;
        end
        ST_CAS2:
        begin
          cas2_next = 1'b1;
          out_next  = {hi_reg, ca_i};
          st_next   = ST_IDLE;
        end
        ST_SKIP: st_next = ST_IDLE;
        default: st_next = ST_IDLE;
      endcase
  end

  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      st_reg   <= ST_IDLE;
      hi_reg   <= 1'b0;
      ma_reg   <= 6'h00;
      op7_reg  <= 1'b0;
      out_reg  <= 7'h00;
      mrw_reg  <= 1'b0;
      mpc_reg  <= 1'b0;
      cas2_reg <= 1'b0;
      oth_reg  <= 1'b0;
    end
    else
    begin
      st_reg   <= st_next;
      hi_reg   <= hi_next;
      ma_reg   <= ma_next;
      op7_reg  <= op7_next;
      out_reg  <= out_next;
      mrw_reg  <= mrw_next;
      mpc_reg  <= mpc_next;
      cas2_reg <= cas2_next;
      oth_reg  <= oth_next;
    end
  end

  assign bus.mrw_v   = mrw_reg;
  assign bus.mr_addr = ma_reg;
  assign bus.mr_op   = {op7_reg, out_reg};
  assign bus.mpc_v   = mpc_reg;
  assign bus.cas2_v  = cas2_reg;
  assign bus.cmd_op  = out_reg;
  assign bus.other_v = oth_reg;

  default clocking dcb @(posedge clk_i); endclocking
  default disable iff (!rst_n_i);

  chk_mpc_operand: assert property (edge_i && st_reg == ST_MPC  // see RULE16
    |=> mpc_reg && out_reg == {$past(hi_reg), $past(ca_i)})
    else $error("multipurpose operand not assembled from both edges");
  chk_op6_first: assert property (edge_i && st_reg == ST_IDLE && cs_i  // see RULE17
    && ca_i[4:0] == lwm_pkg::CA_MPC |=> st_reg == ST_MPC && hi_reg == $past(ca_i[5]))
    else $error("top operand bit not taken on first edge");

endmodule : lwm_cmd_dec
`default_nettype wire

// [hdl/lwm_wl_mpc.sv]
// Behaviour
// RULE1 - Setting leveling bit seven of register two enters write leveling.
// RULE2 - Data pins may be undefined after entry until feedback appears.
// RULE3 - During leveling the controller sends only deselects or the exit write.
// RULE4 - Clearing that bit by a register write leaves write leveling.
// RULE5 - Each strobe rise samples clock level onto all eight bits of its byte.
// RULE6 - Bytes level independently; channels enter and leave leveling independently.
// RULE7 - Controller drives strobe idle no earlier than twenty clocks after entry.
// RULE8 - Controller gives first strobe edge at least forty clocks after entry.
// RULE9 - At least two strobe pulses; each new edge overwrites the captured level.
// RULE10 - Feedback appears on data bits within zero to twenty ns.
// RULE11 - Controller adjusts strobe delay from feedback, repeats, then exits.
// RULE12 - Clock may stop outside strobe toggling, true low, complement high, select low.
// RULE13 - Running clock of max 7.5ns or four clocks around each strobe burst.
// RULE14 - Clock may stop or change between stable frequencies during leveling.
// RULE15 - Finish write leveling before strobe-to-data write training.
// RULE16 - Multipurpose command recognised from select and CA; seven operand bits decoded.
// RULE17 - Top operand bit read on first edge; zero is no operation.
// RULE18 - FIFO and calibration commands are followed at once by CAS-2.
// RULE19 - Training latency counts from the second edge of the paired CAS-2.
// RULE20 - CAS-2 after a training read or write carries all-zero operands.
// RULE21 - Oscillator and impedance calibration commands act alone, without CAS-2.
// RULE22 - Training operand codes decode as listed; all other codes are reserved. Code: codes with top bit clear decode as no operation.
// RULE23 - Feedback bit high for sampled clock high, low for sampled low.
`timescale 1ns/100ps
`default_nettype none
module lwm_wl_mpc #(
  parameter int unsigned BYTES = 2  // Strobe lanes in this channel
) (
  input  wire logic               sys_clk_i,         // System clock, 125 MHz
  input  wire logic               nrst_i,            // Async reset, active low
  input  wire logic               ck_t_i,            // Link clock, true line
  input  wire logic               cs_i,              // Chip select
  input  wire logic [5:0]         ca_i,              // Command/address
  input  wire logic [BYTES-1:0]   dqs_t_i,           // Strobes, true lines
  output var  logic [8*BYTES-1:0] dq_o,              // Data pin drive value
  output var  logic [8*BYTES-1:0] dq_oe_o,           // Data pin enable
  output var  logic               wl_active_o,       // Write leveling active
  output var  logic               train_wr_start_o,  // FIFO write latency start
  output var  logic               train_rd_start_o,  // FIFO read latency start
  output var  logic               rdcal_start_o,     // Read calibration start
  output var  logic               osc_run_o,         // Strobe oscillator running
  output var  logic               zq_start_o,        // Impedance cal start pulse
  output var  logic               zq_latch_o,        // Impedance cal latch pulse
  output var  logic               cmd_err_o          // Protocol error pulse
);

  localparam int unsigned DQW    = 8 * BYTES;
  localparam int unsigned SW     = 8 + BYTES;
  localparam int          FB_CYC = int'(lwm_pkg::FB_DELAY_CYC);

  if (BYTES < 1 || BYTES > 4)
  begin : g_bad_bytes
    $error("BYTES must be 1 to 4");
  end

  logic [1:0] rst_sync_reg;
  logic       rst_n;

  always_ff @(posedge sys_clk_i or negedge nrst_i)
  begin
    if (!nrst_i)
      rst_sync_reg <= 2'h0;
    else
      rst_sync_reg <= {rst_sync_reg[0], 1'b1};
  end
  assign rst_n = rst_sync_reg[1];

  // Third stage is history for edge detection only
  logic [SW-1:0]    pin_s1_reg, pin_s2_reg, pin_s3_reg;
  logic             ck_lvl, ck_rise;
  logic [BYTES-1:0] dqs_rise;

  always_ff @(posedge sys_clk_i or negedge rst_n)
  begin
    if (!rst_n)
    begin
      pin_s1_reg <= '0;
      pin_s2_reg <= '0;
      pin_s3_reg <= '0;
    end
    else
    begin
      pin_s1_reg <= {ck_t_i, cs_i, ca_i, dqs_t_i};
      pin_s2_reg <= pin_s1_reg;
      pin_s3_reg <= pin_s2_reg;
    end
  end

  assign ck_lvl   = pin_s2_reg[SW-1];
  assign ck_rise  = ck_lvl & ~pin_s3_reg[SW-1];
  assign dqs_rise = pin_s2_reg[BYTES-1:0] & ~pin_s3_reg[BYTES-1:0];

  lwm_cmd_if cmd ();

  lwm_cmd_dec u_dec (
    .clk_i   (sys_clk_i),
    .rst_n_i (rst_n),
    .edge_i  (ck_rise),
    .cs_i    (pin_s2_reg[SW-2]),
    .ca_i    (pin_s2_reg[SW-3:BYTES]),
    .bus     (cmd.dec)
  );

  logic             wl_reg, wl_next;
  logic [5:0]       cnt_reg, cnt_next;
  logic [DQW-1:0]   dq_reg, dq_next;
  logic [DQW-1:0]   oe_reg, oe_next;
  lwm_pkg::lwm_mpc_t pend_reg, pend_next;
  lwm_pkg::lwm_mpc_t mpc_k;
  logic             osc_reg, osc_next;
  logic             wrs_reg, wrs_next;
  logic             rds_reg, rds_next;
  logic             cal_reg, cal_next;
  logic             zqs_reg, zqs_next;
  logic             zql_reg, zql_next;
  logic             err_reg, err_next;

  always_comb
  begin
    wl_next   = wl_reg;
    cnt_next  = cnt_reg;
    dq_next   = dq_reg;
    pend_next = pend_reg;
    osc_next  = osc_reg;
    wrs_next  = 1'b0;
    rds_next  = 1'b0;
    cal_next  = 1'b0;
    zqs_next  = 1'b0;
    zql_next  = 1'b0;
    err_next  = 1'b0;
    mpc_k     = lwm_pkg::lwm_mpc_decode(cmd.cmd_op);  // see RULE22

    if (cmd.mrw_v && cmd.mr_addr == lwm_pkg::MR_LEVEL_ADDR)
    begin
      wl_next  = cmd.mr_op[lwm_pkg::MR_LEVEL_BIT];  // see RULE1 RULE4
      cnt_next = 6'h00;
    end
    // Only deselects and register writes are legal while leveling
    if (wl_reg && (cmd.mpc_v || cmd.cas2_v || cmd.other_v))
      err_next = 1'b1;  // see RULE3
    // Counts clock edges only; a stopped clock simply pauses it
    if (wl_reg && ck_rise && cnt_reg != lwm_pkg::FIRST_EDGE_TCK)
      cnt_next = cnt_reg + 6'h01;

    for (int b = 0; b < BYTES; b++)
      if (wl_reg && dqs_rise[b])
      begin
        dq_next[8*b +: 8] = {8{ck_lvl}};  // see RULE5 RULE6 RULE9 RULE10 RULE23
        if (cnt_reg != lwm_pkg::FIRST_EDGE_TCK)
          err_next = 1'b1;  // see RULE8
      end
    // Driven low from entry until the first strobe edge
    if (!wl_next)
      dq_next = '0;  // see RULE2
    oe_next = {DQW{wl_next}};

    if (cmd.mpc_v)
    begin
      if (pend_reg != lwm_pkg::MPC_NOP)
        err_next = 1'b1;  // see RULE18
      if (mpc_k == lwm_pkg::MPC_RSVD)
        err_next = 1'b1;  // see RULE22
      pend_next = lwm_pkg::lwm_needs_cas2(mpc_k) ? mpc_k : lwm_pkg::MPC_NOP;
      if (mpc_k == lwm_pkg::MPC_OSC_START)
        osc_next = 1'b1;  // see RULE21
      if (mpc_k == lwm_pkg::MPC_OSC_STOP)
        osc_next = 1'b0;  // see RULE21
      zqs_next = (mpc_k == lwm_pkg::MPC_ZQ_START);  // see RULE21
      zql_next = (mpc_k == lwm_pkg::MPC_ZQ_LATCH);  // see RULE21
    end
    if (cmd.cas2_v && pend_reg != lwm_pkg::MPC_NOP)
    begin
      wrs_next  = (pend_reg == lwm_pkg::MPC_WR_FIFO);  // see RULE19
      rds_next  = (pend_reg == lwm_pkg::MPC_RD_FIFO);  // see RULE19
      cal_next  = (pend_reg == lwm_pkg::MPC_RD_CAL);   // see RULE19
      pend_next = lwm_pkg::MPC_NOP;
      if (cmd.cmd_op != 7'h00)
        err_next = 1'b1;  // see RULE20
    end
    // Any command but CAS-2 breaks the pairing; the training command is dropped
    if ((cmd.mrw_v || cmd.other_v) && pend_reg != lwm_pkg::MPC_NOP)
    begin
      err_next  = 1'b1;  // see RULE18
      pend_next = lwm_pkg::MPC_NOP;
    end
  end

  always_ff @(posedge sys_clk_i or negedge rst_n)
  begin
    if (!rst_n)
    begin
      wl_reg   <= lwm_pkg::WL_RESET;
      cnt_reg  <= 6'h00;
      dq_reg   <= '0;
      oe_reg   <= '0;
      pend_reg <= lwm_pkg::MPC_NOP;
      osc_reg  <= lwm_pkg::OSC_RESET;
      wrs_reg  <= 1'b0;
      rds_reg  <= 1'b0;
      cal_reg  <= 1'b0;
      zqs_reg  <= 1'b0;
      zql_reg  <= 1'b0;
      err_reg  <= 1'b0;
    end
    else
    begin
      wl_reg   <= wl_next;
      cnt_reg  <= cnt_next;
      dq_reg   <= dq_next;
      oe_reg   <= oe_next;
      pend_reg <= pend_next;
      osc_reg  <= osc_next;
      wrs_reg  <= wrs_next;
      rds_reg  <= rds_next;
      cal_reg  <= cal_next;
      zqs_reg  <= zqs_next;
      zql_reg  <= zql_next;
      err_reg  <= err_next;
    end
  end

  assign dq_o             = dq_reg;
  assign dq_oe_o          = oe_reg;
  assign wl_active_o      = wl_reg;
  assign train_wr_start_o = wrs_reg;
  assign train_rd_start_o = rds_reg;
  assign rdcal_start_o    = cal_reg;
  assign osc_run_o        = osc_reg;
  assign zq_start_o       = zqs_reg;
  assign zq_latch_o       = zql_reg;
  assign cmd_err_o        = err_reg;

  default clocking dcb @(posedge sys_clk_i); endclocking
  default disable iff (!rst_n);

  chk_level_entry: assert property (cmd.mrw_v && cmd.mr_addr == 6'h02  // see RULE1
    && cmd.mr_op[7] |=> wl_active_o && dq_oe_o == {DQW{1'b1}})
    else $error("leveling not entered on bit set");
  chk_level_exit: assert property (cmd.mrw_v && cmd.mr_addr == 6'h02  // see RULE4
    && !cmd.mr_op[7] |=> !wl_active_o && dq_oe_o == '0)
    else $error("leveling not left on bit clear");
  chk_fb_value: assert property (wl_reg && wl_next && dqs_rise[0]  // see RULE5 RULE23
    |=> dq_o[7:0] == {8{$past(ck_lvl)}})
    else $error("byte 0 feedback differs from sampled clock");
  chk_fb_delay: assert property (wl_reg && wl_next && dqs_rise[BYTES-1]  // see RULE10
    |-> ##[1:FB_CYC] dq_o[8*BYTES-1] == $past(ck_lvl, 1))
    else $error("feedback late");
  chk_lane_indep: assert property (wl_reg && wl_next && dqs_rise[BYTES-1]  // see RULE6
    && !dqs_rise[0] && BYTES > 1 |=> $stable(dq_o[7:0]))
    else $error("strobe of one byte changed another byte");
  // A high level already on the byte shows an earlier capture to be overwritten
  chk_overwrite: assert property (wl_reg && wl_next && dqs_rise[0] && !ck_lvl  // see RULE9
    && dq_o[0] |=> dq_o[0] == 1'b0)
    else $error("later strobe edge did not overwrite");
  chk_pair_start: assert property (cmd.cas2_v && pend_reg == lwm_pkg::MPC_RD_FIFO  // see RULE19
    |=> train_rd_start_o && !train_wr_start_o ##1 !train_rd_start_o)
    else $error("paired read did not start latency once");
  chk_alone_zq: assert property (cmd.mpc_v && cmd.cmd_op == 7'h4F  // see RULE21
    |=> zq_start_o && pend_reg == lwm_pkg::MPC_NOP)
    else $error("impedance start not acted on alone");
  chk_reserved: assert property (cmd.mpc_v && cmd.cmd_op == 7'h45  // see RULE22
    |=> cmd_err_o && !zq_start_o && !osc_run_o == !$past(osc_reg))
    else $error("reserved operand not refused");
  chk_wl_only_desel: assert property (wl_reg && cmd.mpc_v  // see RULE3
    |=> cmd_err_o)
    else $error("command in leveling not flagged");

  cov_entry: cover property (cmd.mrw_v && cmd.mr_op[7] ##1 wl_active_o);
  cov_fb_high: cover property (wl_reg && dqs_rise[0] && ck_lvl ##1 dq_o[0]);
  cov_rd_pair: cover property (cmd.mpc_v ##[1:30] train_rd_start_o);
  cov_zq: cover property (zq_start_o);

endmodule : lwm_wl_mpc
`default_nettype wire

// [tb/lwm_ctrl_model.sv]
`timescale 1ns/100ps
`default_nettype none
module lwm_ctrl_model #(
  parameter int unsigned BYTES = 2  // Strobe lanes driven
) (
  input  wire logic             sys_clk_i,  // Bench clock, 125 MHz
  output var  logic             ck_t_o,     // Link clock, true line
  output var  logic             cs_o,       // Chip select
  output var  logic [5:0]       ca_o,       // Command/address
  output var  logic [BYTES-1:0] dqs_t_o     // Strobes, true lines
);
  logic       ck_run;
  logic [2:0] ck_cnt;

  initial
  begin
    ck_t_o  = 1'b0;
    cs_o    = 1'b0;
    ca_o    = 6'h00;
    dqs_t_o = '0;
    ck_run  = 1'b1;
    ck_cnt  = 3'h0;
  end

  // 80 ns link clock; a stopped clock parks low
  always @(posedge sys_clk_i)
  begin
    if (!ck_run)
    begin
      ck_t_o <= 1'b0;
      ck_cnt <= 3'h0;
    end
    else if (ck_cnt == 3'h4)
    begin
      ck_t_o <= ~ck_t_o;
      ck_cnt <= 3'h0;
    end
    else
      ck_cnt <= ck_cnt + 3'h1;
  end

  // CA moves on the falling clock edge, so it is stable around each rise
  task automatic edge_drive(input logic cs, input logic [5:0] ca);
    @(negedge ck_t_o);
    cs_o <= cs;
    ca_o <= ca;
  endtask : edge_drive

  task automatic cmd(input logic [4:0] code, input logic hi, input logic [5:0] lo);
    edge_drive(1'b1, {hi, code});
    edge_drive(1'b0, lo);
  endtask : cmd

  // Unselected CA lines must not keep their last value
  task automatic desel();
    edge_drive(1'b0, ~ca_o);
  endtask : desel

  task automatic mrw(input logic [5:0] ma, input logic [7:0] op);
    cmd(lwm_pkg::CA_MRW1, op[7], ma);
    cmd(lwm_pkg::CA_MRW2, op[6], op[5:0]);
    desel();
  endtask : mrw

  // Two pulses, as the first rise may be lost; rise sits mid-level
  task automatic strobe(input int unsigned lane, input logic level);
    repeat (2)
    begin
      if (level)
        @(posedge ck_t_o);
      else
        @(negedge ck_t_o);
      repeat (2) @(posedge sys_clk_i);
      dqs_t_o[lane] <= 1'b1;
      repeat (5) @(posedge sys_clk_i);
      dqs_t_o[lane] <= 1'b0;
    end
  endtask : strobe

  task automatic stop_clock(input int unsigned cycles);
    @(negedge ck_t_o);
    cs_o   <= 1'b0;
    ck_run <= 1'b0;
    repeat (cycles) @(posedge sys_clk_i);
    ck_run <= 1'b1;
    repeat (4) @(posedge ck_t_o);
  endtask : stop_clock
endmodule : lwm_ctrl_model
`default_nettype wire

// [tb/lwm_wl_mpc_tb.sv]
`timescale 1ns/100ps
`default_nettype none
module lwm_wl_mpc_tb;
  localparam int unsigned BYTES = 2;
  localparam int unsigned CEIL  = 10000;

  logic        sys_clk     = 1'b0;
  logic        nrst        = 1'b0;
  logic        clr         = 1'b0;
  logic [5:0]  seen        = 6'h00;
  int unsigned n_mismatch  = 0;
  int unsigned comparisons = 0;
  int unsigned cycles      = 0;
  wire  logic             ck_t;
  wire  logic             cs;
  wire  logic [5:0]       ca;
  wire  logic [BYTES-1:0] dqs_t;
  wire  logic [15:0]      dq;
  wire  logic [15:0]      dq_oe;
  wire  logic             wl_act;
  wire  logic             tr_wr;
  wire  logic             tr_rd;
  wire  logic             rdcal;
  wire  logic             osc_run;
  wire  logic             zq_st;
  wire  logic             zq_lt;
  wire  logic             err;

  always #4 sys_clk = ~sys_clk;

  lwm_ctrl_model #(.BYTES(BYTES)) model (
    .sys_clk_i (sys_clk),
    .ck_t_o    (ck_t),
    .cs_o      (cs),
    .ca_o      (ca),
    .dqs_t_o   (dqs_t)
  );

  lwm_wl_mpc #(.BYTES(BYTES)) dut (
    .sys_clk_i        (sys_clk),
    .nrst_i           (nrst),
    .ck_t_i           (ck_t),
    .cs_i             (cs),
    .ca_i             (ca),
    .dqs_t_i          (dqs_t),
    .dq_o             (dq),
    .dq_oe_o          (dq_oe),
    .wl_active_o      (wl_act),
    .train_wr_start_o (tr_wr),
    .train_rd_start_o (tr_rd),
    .rdcal_start_o    (rdcal),
    .osc_run_o        (osc_run),
    .zq_start_o       (zq_st),
    .zq_latch_o       (zq_lt),
    .cmd_err_o        (err)
  );

  // Sticky record of one-cycle pulses, so none is missed between checks
  always @(posedge sys_clk)
    seen <= clr ? 6'h00 : (seen | {err, zq_lt, zq_st, rdcal, tr_rd, tr_wr});

  task automatic summarize();
    $display("comparisons %0d mismatches %0d", comparisons, n_mismatch);
    if (n_mismatch == 0 && comparisons > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask : summarize

  always @(posedge sys_clk)
  begin
    cycles++;
    if (cycles == CEIL)
    begin
      n_mismatch++;
      summarize();
    end
  end

  task automatic check(input logic [15:0] got, input logic [15:0] exp);
    comparisons++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : check

  task automatic clear_seen();
    clr <= 1'b1;
    @(posedge sys_clk);
    clr <= 1'b0;
  endtask : clear_seen

  // Modes: 0 alone, 1 CAS-2, 2 bad CAS-2, 3 then ZQ start, 4 CAS-2 only, 5 then other
  task automatic run_mpc(input logic [6:0] op, input int unsigned mode,
                         input logic [5:0] exp_seen, input logic exp_osc);
    clear_seen();
    if (mode != 4)
      model.cmd(lwm_pkg::CA_MPC, op[6], op[5:0]);
    if (mode == 1 || mode == 4)
      model.cmd(lwm_pkg::CA_CAS2, 1'b0, 6'h00);
    if (mode == 2)
      model.cmd(lwm_pkg::CA_CAS2, 1'b0, 6'h01);
    if (mode == 3)
      model.cmd(lwm_pkg::CA_MPC, 1'b1, lwm_pkg::OP_ZQ_START[5:0]);
    if (mode == 5)
      model.cmd(5'h01, 1'b0, 6'h00);
    model.desel();
    repeat (25) @(posedge sys_clk);
    check({10'h000, seen}, {10'h000, exp_seen});
    check({15'h0000, osc_run}, {15'h0000, exp_osc});
  endtask : run_mpc

  task automatic t_reset_state();
    check(dq_oe, 16'h0000);
    check({15'h0000, wl_act}, 16'h0000);
  endtask : t_reset_state

  task automatic t_mpc_alone();
    run_mpc(7'h00, 0, 6'h00, 1'b0);
    run_mpc(7'h3F, 0, 6'h00, 1'b0);
    run_mpc(lwm_pkg::OP_OSC_START, 0, 6'h00, 1'b1);
    run_mpc(lwm_pkg::OP_OSC_STOP, 0, 6'h00, 1'b0);
    run_mpc(lwm_pkg::OP_ZQ_START, 0, 6'h08, 1'b0);
    run_mpc(lwm_pkg::OP_ZQ_LATCH, 0, 6'h10, 1'b0);
  endtask : t_mpc_alone

  task automatic t_mpc_paired();
    run_mpc(lwm_pkg::OP_RD_FIFO, 1, 6'h02, 1'b0);
    run_mpc(lwm_pkg::OP_RD_CAL, 1, 6'h04, 1'b0);
    run_mpc(lwm_pkg::OP_WR_FIFO, 1, 6'h01, 1'b0);
  endtask : t_mpc_paired

  task automatic t_mpc_faults();
    run_mpc(7'h45, 0, 6'h20, 1'b0);
    run_mpc(7'h7F, 0, 6'h20, 1'b0);
    run_mpc(lwm_pkg::OP_WR_FIFO, 2, 6'h21, 1'b0);
    run_mpc(lwm_pkg::OP_RD_FIFO, 3, 6'h28, 1'b0);
    run_mpc(7'h00, 4, 6'h00, 1'b0);
    run_mpc(lwm_pkg::OP_RD_FIFO, 5, 6'h20, 1'b0);
  endtask : t_mpc_faults

  task automatic t_leveling();
    clear_seen();
    model.mrw(6'h03, 8'h80);
    repeat (8) @(posedge sys_clk);
    check({15'h0000, wl_act}, 16'h0000);
    model.mrw(lwm_pkg::MR_LEVEL_ADDR, 8'h80);
    repeat (8) @(posedge sys_clk);
    check({15'h0000, wl_act}, 16'h0001);
    check(dq_oe, 16'hFFFF);
    repeat (42) @(posedge ck_t);
    model.strobe(1, 1'b1);
    check(dq, 16'hFF00);
    model.strobe(0, 1'b1);
    check(dq, 16'hFFFF);
    model.stop_clock(30);
    model.strobe(1, 1'b0);
    check(dq, 16'h00FF);
    model.strobe(0, 1'b0);
    check(dq, 16'h0000);
    repeat (4) @(posedge ck_t);
    check({10'h000, seen}, 16'h0000);
    // Illegal on purpose: a command while leveling must be flagged
    model.cmd(lwm_pkg::CA_MPC, 1'b0, 6'h00);
    model.desel();
    repeat (25) @(posedge sys_clk);
    check({10'h000, seen}, 16'h0020);
    model.mrw(lwm_pkg::MR_LEVEL_ADDR, 8'h00);
    repeat (8) @(posedge sys_clk);
    check({15'h0000, wl_act}, 16'h0000);
    check(dq_oe, 16'h0000);
  endtask : t_leveling

  initial
  begin
    repeat (3) @(posedge sys_clk);
    nrst <= 1'b1;
    repeat (6) @(posedge sys_clk);
    t_reset_state();
    t_leveling();
    t_mpc_alone();
    t_mpc_paired();
    t_mpc_faults();
    summarize();
  end
endmodule : lwm_wl_mpc_tb
`default_nettype wire
